// *** converter_defs.svh ***
// Constants for the converter enable, fault and power-good control block.
`ifndef CONVERTER_DEFS_SVH
`define CONVERTER_DEFS_SVH
`define CMD_OPERATION 8'h01
`define CMD_ON_OFF_CONFIG 8'h02
`define CMD_CLEAR_FAULTS 8'h03
`define CMD_VOUT_TRIM 8'h22
`define CMD_MARGIN_HIGH 8'h25
`define CMD_MARGIN_LOW 8'h26
`define CMD_INPUT_TURN_ON_LEVEL 8'h35
`define CMD_INPUT_TURN_OFF_LEVEL 8'h36
`define CMD_OV_LIMIT 8'h40
`define CMD_OV_ACTION 8'h41
`define CMD_UV_LIMIT 8'h44
`define CMD_UV_ACTION 8'h45
`define CMD_OC_ACTION 8'h47
`define CMD_OT_ACTION 8'h50
`define CMD_PG_ON 8'h5e
`define CMD_PG_OFF 8'h5f
`define CMD_SOFT_START_DURATION 8'h61
`define CMD_FAULT_STATUS 8'h78
`define CMD_READ_IOUT 8'h8c
`define CMD_SCRATCHPAD 8'hd0
`define RST_OPERATION 8'h00
`define RST_ON_OFF_CONFIG 8'h17
`define RST_ACTION 8'h04
`define RST_WORD 16'h0000
`define RST_MARGIN 16'h001e
`define RST_INPUT_TURN_ON_LEVEL 16'h000b
`define RST_INPUT_TURN_OFF_LEVEL 16'h000a
`define RST_OV_LIMIT 16'h0001
`define RST_UV_LIMIT 16'h0001
`define RST_PG_ON 16'h0000
`define RST_PG_OFF 16'h0001
`define RST_SOFT_START_DURATION 16'h0001
`define OP_ON_BIT 7
`define OP_MARGIN_HI 5
`define OP_MARGIN_LO 4
`define ONOFF_CMD_BIT 3
`define ONOFF_PIN_BIT 2
`define ONOFF_POL_BIT 1
`define SCR_DEAD_BIT 0
`define SCR_LOCK_BIT 1
`define SCR_WIDTH 14
`define ACTION_MODE_HI 7
`define ACTION_MODE_LO 6
`define REF_NOM_MV 16'h0258
`define CLK_MHZ 20
`define SS_US0 600
`define SS_US1 1500
`define SS_US2 3000
`define SS_US3 9000
`define PG_DEV0 16'h001e
`define PG_DEV1 16'h002a
`define PG_DEV2 16'h003c
`define FLT_DEV0 16'h0030
`define FLT_DEV1 16'h003c
`define FLT_DEV2 16'h0048
`define FLT_DEV3 16'h005a
`define AVG_SHIFT 4
`define AVG_LAST 4'hf
`endif

// *** converter_pkg.sv ***
// Types shared by the converter control block and its users.
package converter_pkg;
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] code;
    logic [15:0] wdata;
  } cmd_t;
  typedef struct packed {
    logic valid;
    logic err;
    logic [15:0] data;
  } rsp_t;
  typedef struct packed {
    logic ot;
    logic oc;
    logic uv;
    logic ov;
  } fault_t;
  typedef enum logic [1:0] {PH_OFF, PH_RAMP, PH_REGULATE} phase_t;
endpackage

// *** converter_enable_fault_control.sv ***
// Enable selection, soft-start and margin ramp, power good, fault responses and current readback.
`timescale 1ns/1ps
`include "converter_defs.svh"
//
// Function
// - Current readback never negative; sinking current reads zero.
// - Current readback is the average of many sense samples.
// - Four soft-start durations, 600 us to 9 ms, chosen by the duration register.
// - Three power-good threshold settings decide when power good may rise.
// - Each power-good setting is a symmetric window around the target reference.
// - Power good low during start-up, after faults and while disabled.
// - Separate input turn-on and turn-off lockout thresholds with hysteresis.
// - Four selectable overvoltage and undervoltage fault thresholds.
// - Separate response for overcurrent, overtemperature, overvoltage, undervoltage.
// - Response either ignores the fault or latches the converter off.
// - Fourteen-bit user scratchpad holds arbitrary data.
// - Scratchpad bit 0 selects short or long dead time.
// - Writing scratchpad bit 1 as one locks parameters for good.
// - Always continuous conduction at fixed frequency.
// - Pin mode: only the enable pin controls regulation.
// - Enable pin polarity selectable active high or active low.
// - Command mode: only the operation command controls regulation.
// - Combined mode: both pin and command must request enable.
// - Neither mode: run whenever input lockout thresholds allow.
// - Operation selects no margin, margin low or margin high reference.
// - Margin changes ramp at the soft-start slope.
// - On/off configuration resets to pin only, active high.
// - Operation resets to no margin and off.
// - Clear faults zeroes fault status and releases the alert.
module converter_enable_fault_control #(
  parameter int unsigned SS_CYC0 = `SS_US0 * `CLK_MHZ,
  parameter int unsigned SS_CYC1 = `SS_US1 * `CLK_MHZ,
  parameter int unsigned SS_CYC2 = `SS_US2 * `CLK_MHZ,
  parameter int unsigned SS_CYC3 = `SS_US3 * `CLK_MHZ
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_resetn,
  // Command port
  input wire converter_pkg::cmd_t i_cmd,
  output converter_pkg::rsp_t o_rsp,
  // Power stage sense inputs
  input wire logic i_enable_input_pin,
  input wire logic [15:0] i_vin_code,
  input wire logic [15:0] i_feedback_pin_mv,
  input wire logic i_oc_trip,
  input wire logic i_ot_trip,
  input wire logic [15:0] i_current_sense_pins_mv,
  input wire logic i_current_sense_pins_strobe,
  // Power stage controls and status
  output logic o_run,
  output logic [15:0] o_ref_mv,
  output logic o_continuous_conduction,
  output logic o_dead_time_long,
  output logic o_output_ok_pin,
  output logic o_alert
);
  import converter_pkg::*;

  function automatic logic [15:0] pg_dev(input logic [15:0] code);
    unique case (code[1:0])
      2'h0: pg_dev = `PG_DEV0;
      2'h1: pg_dev = `PG_DEV1;
      default: pg_dev = `PG_DEV2;
    endcase
  endfunction

  function automatic logic [15:0] flt_dev(input logic [15:0] code);
    unique case (code[1:0])
      2'h0: flt_dev = `FLT_DEV0;
      2'h1: flt_dev = `FLT_DEV1;
      2'h2: flt_dev = `FLT_DEV2;
      default: flt_dev = `FLT_DEV3;
    endcase
  endfunction

  function automatic logic latch_action(input logic [7:0] act);
    latch_action = |act[`ACTION_MODE_HI:`ACTION_MODE_LO];
  endfunction

  // Reset release and pin synchronisers.
  logic [1:0] rst_ff;
  logic rst_n;
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      rst_ff <= 2'h0;
    else
      rst_ff <= {rst_ff[0], 1'b1};
  end
  assign rst_n = rst_ff[1];

  logic [51:0] meta, sync;
  logic strobe_d;
  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta <= '0;
      sync <= '0;
      strobe_d <= 1'b0;
    end
    else
    begin
      meta <= {i_enable_input_pin, i_vin_code, i_feedback_pin_mv, i_oc_trip, i_ot_trip,
               i_current_sense_pins_mv, i_current_sense_pins_strobe};
      sync <= meta;
      strobe_d <= sync[0];
    end
  end
  logic pin_s, oc_s, ot_s, strobe_rise;
  logic [15:0] vin_s, fb_s, current_sense_pins_s;
  assign {pin_s, vin_s, fb_s, oc_s, ot_s, current_sense_pins_s} = sync[51:1];
  assign strobe_rise = sync[0] & ~strobe_d;

  // Register file.
  logic [7:0] operation, onoff, ov_act, uv_act, oc_act, ot_act;
  logic [15:0] trim, mhigh, mlow, input_turn_on_level, input_turn_off_level, ov_lim, uv_lim, pg_on, pg_off, ton, iout;
  logic [`SCR_WIDTH-1:0] scratch;
  logic locked;
  fault_t status;
  logic [7:0] next_operation, next_onoff, next_ov_act, next_uv_act, next_oc_act, next_ot_act;
  logic [15:0] next_trim, next_mhigh, next_mlow, next_input_turn_on_level, next_input_turn_off_level, next_ov_lim;
  logic [15:0] next_uv_lim, next_pg_on, next_pg_off, next_ton;
  logic [`SCR_WIDTH-1:0] next_scratch;
  logic next_locked, wr, rd, clr;
  rsp_t next_rsp;

  assign wr = i_cmd.valid & i_cmd.write;
  assign rd = i_cmd.valid & ~i_cmd.write;
  assign clr = wr & (i_cmd.code == `CMD_CLEAR_FAULTS);

  always_comb
  begin
    next_operation = operation;
    next_onoff = onoff;
    next_trim = trim;
    next_mhigh = mhigh;
    next_mlow = mlow;
    next_input_turn_on_level = input_turn_on_level;
    next_input_turn_off_level = input_turn_off_level;
    next_ov_lim = ov_lim;
    next_ov_act = ov_act;
    next_uv_lim = uv_lim;
    next_uv_act = uv_act;
    next_oc_act = oc_act;
    next_ot_act = ot_act;
    next_pg_on = pg_on;
    next_pg_off = pg_off;
    next_ton = ton;
    next_scratch = scratch;
    next_locked = locked;
    if (wr)
    begin
      unique case (i_cmd.code)
        `CMD_OPERATION: next_operation = i_cmd.wdata[7:0];
        `CMD_ON_OFF_CONFIG: next_onoff = i_cmd.wdata[7:0];
        `CMD_VOUT_TRIM: next_trim = i_cmd.wdata;
        `CMD_MARGIN_HIGH: next_mhigh = i_cmd.wdata;
        `CMD_MARGIN_LOW: next_mlow = i_cmd.wdata;
        default: ;
      endcase
      if (!locked)
      begin
        unique case (i_cmd.code)
          `CMD_INPUT_TURN_ON_LEVEL: next_input_turn_on_level = i_cmd.wdata;
          `CMD_INPUT_TURN_OFF_LEVEL: next_input_turn_off_level = i_cmd.wdata;
          `CMD_OV_LIMIT: next_ov_lim = i_cmd.wdata;
          `CMD_OV_ACTION: next_ov_act = i_cmd.wdata[7:0];
          `CMD_UV_LIMIT: next_uv_lim = i_cmd.wdata;
          `CMD_UV_ACTION: next_uv_act = i_cmd.wdata[7:0];
          `CMD_OC_ACTION: next_oc_act = i_cmd.wdata[7:0];
          `CMD_OT_ACTION: next_ot_act = i_cmd.wdata[7:0];
          `CMD_PG_ON: next_pg_on = i_cmd.wdata;
          `CMD_PG_OFF: next_pg_off = i_cmd.wdata;
          `CMD_SOFT_START_DURATION: next_ton = i_cmd.wdata;
          `CMD_SCRATCHPAD:
          begin
            next_scratch = i_cmd.wdata[`SCR_WIDTH-1:0];
            next_locked = i_cmd.wdata[`SCR_LOCK_BIT];
          end
          default: ;
        endcase
      end
    end
    next_rsp = '0;
    next_rsp.valid = rd;
    unique case (i_cmd.code)
      `CMD_OPERATION: next_rsp.data = {8'h00, operation};
      `CMD_ON_OFF_CONFIG: next_rsp.data = {8'h00, onoff};
      `CMD_VOUT_TRIM: next_rsp.data = trim;
      `CMD_MARGIN_HIGH: next_rsp.data = mhigh;
      `CMD_MARGIN_LOW: next_rsp.data = mlow;
      `CMD_INPUT_TURN_ON_LEVEL: next_rsp.data = input_turn_on_level;
      `CMD_INPUT_TURN_OFF_LEVEL: next_rsp.data = input_turn_off_level;
      `CMD_OV_LIMIT: next_rsp.data = ov_lim;
      `CMD_OV_ACTION: next_rsp.data = {8'h00, ov_act};
      `CMD_UV_LIMIT: next_rsp.data = uv_lim;
      `CMD_UV_ACTION: next_rsp.data = {8'h00, uv_act};
      `CMD_OC_ACTION: next_rsp.data = {8'h00, oc_act};
      `CMD_OT_ACTION: next_rsp.data = {8'h00, ot_act};
      `CMD_PG_ON: next_rsp.data = pg_on;
      `CMD_PG_OFF: next_rsp.data = pg_off;
      `CMD_SOFT_START_DURATION: next_rsp.data = ton;
      `CMD_FAULT_STATUS: next_rsp.data = {12'h000, status};
      `CMD_READ_IOUT: next_rsp.data = iout;
      `CMD_SCRATCHPAD: next_rsp.data = {2'h0, scratch};
      default: next_rsp.err = rd;
    endcase
  end

  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      operation <= `RST_OPERATION;
      onoff <= `RST_ON_OFF_CONFIG;
      trim <= `RST_WORD;
      mhigh <= `RST_MARGIN;
      mlow <= `RST_MARGIN;
      input_turn_on_level <= `RST_INPUT_TURN_ON_LEVEL;
      input_turn_off_level <= `RST_INPUT_TURN_OFF_LEVEL;
      ov_lim <= `RST_OV_LIMIT;
      ov_act <= `RST_ACTION;
      uv_lim <= `RST_UV_LIMIT;
      uv_act <= `RST_ACTION;
      oc_act <= `RST_ACTION;
      ot_act <= `RST_ACTION;
      pg_on <= `RST_PG_ON;
      pg_off <= `RST_PG_OFF;
      ton <= `RST_SOFT_START_DURATION;
      scratch <= '0;
      locked <= 1'b0;
      o_rsp <= '0;
    end
    else
    begin
      operation <= next_operation;
      onoff <= next_onoff;
      trim <= next_trim;
      mhigh <= next_mhigh;
      mlow <= next_mlow;
      input_turn_on_level <= next_input_turn_on_level;
      input_turn_off_level <= next_input_turn_off_level;
      ov_lim <= next_ov_lim;
      ov_act <= next_ov_act;
      uv_lim <= next_uv_lim;
      uv_act <= next_uv_act;
      oc_act <= next_oc_act;
      ot_act <= next_ot_act;
      pg_on <= next_pg_on;
      pg_off <= next_pg_off;
      ton <= next_ton;
      scratch <= next_scratch;
      locked <= next_locked | locked;
      o_rsp <= next_rsp;
    end
  end

  // Enable selection, latch-off, ramp and power good.
  phase_t phase, next_phase;
  logic uvlo_ok, latched, pin_act, cmd_on, en_req, ramp_done, pg_in, pg_out;
  logic next_uvlo_ok, next_latched, next_run, next_pg, next_alert;
  logic [15:0] target, next_ref, tick, next_tick, tick_max;
  fault_t hits, next_status;
  logic latch_hit;

  assign pin_act = pin_s ^ ~onoff[`ONOFF_POL_BIT];
  assign cmd_on = operation[`OP_ON_BIT];

  always_comb
  begin
    unique case ({onoff[`ONOFF_CMD_BIT], onoff[`ONOFF_PIN_BIT]})
      2'b01: en_req = pin_act;
      2'b10: en_req = cmd_on;
      2'b11: en_req = pin_act & cmd_on;
      default: en_req = 1'b1;
    endcase
    // Margin offsets are mV at the feedback pin; the host keeps the sum within range.
    target = 16'(`REF_NOM_MV + trim);
    if (operation[`OP_MARGIN_HI])
      target = 16'(target + mhigh);
    else if (operation[`OP_MARGIN_LO])
      target = 16'(target - mlow);
    unique case (ton[1:0])
      2'h0: tick_max = 16'(SS_CYC0 / `REF_NOM_MV);
      2'h1: tick_max = 16'(SS_CYC1 / `REF_NOM_MV);
      2'h2: tick_max = 16'(SS_CYC2 / `REF_NOM_MV);
      default: tick_max = 16'(SS_CYC3 / `REF_NOM_MV);
    endcase
    ramp_done = (o_ref_mv == target);
    hits.ov = o_run & (fb_s > 16'(target + flt_dev(ov_lim)));
    hits.uv = o_run & (phase == PH_REGULATE) & (16'(fb_s + flt_dev(uv_lim)) < target);
    hits.oc = o_run & oc_s;
    hits.ot = o_run & ot_s;
    latch_hit = (hits.ov & latch_action(ov_act)) | (hits.uv & latch_action(uv_act))
              | (hits.oc & latch_action(oc_act)) | (hits.ot & latch_action(ot_act));
    // A new fault wins over a clear issued in the same cycle.
    next_status = (clr ? fault_t'(4'h0) : status) | hits;
    next_alert = (o_alert & ~clr) | (|hits);
    next_latched = latch_hit | (latched & en_req);
    if (vin_s >= input_turn_on_level)
      next_uvlo_ok = 1'b1;
    else if (vin_s < input_turn_off_level)
      next_uvlo_ok = 1'b0;
    else
      next_uvlo_ok = uvlo_ok;
    next_run = en_req & uvlo_ok & ~next_latched;
    next_phase = phase;
    next_ref = o_ref_mv;
    next_tick = tick;
    if (!next_run)
    begin
      next_phase = PH_OFF;
      next_ref = '0;
      next_tick = '0;
    end
    else
    begin
      if (phase == PH_OFF)
        next_phase = PH_RAMP;
      else if (phase == PH_RAMP && ramp_done)
        next_phase = PH_REGULATE;
      // The same 1 mV step rate serves start-up and margin moves, keeping one slope.
      if (!ramp_done)
      begin
        next_tick = 16'(tick + 16'h0001);
        if (tick >= tick_max)
        begin
          next_tick = '0;
          next_ref = (o_ref_mv < target) ? 16'(o_ref_mv + 16'h0001) : 16'(o_ref_mv - 16'h0001);
        end
      end
    end
    pg_in = (fb_s >= 16'(target - pg_dev(pg_on))) & (fb_s <= 16'(target + pg_dev(pg_on)));
    pg_out = (fb_s < 16'(target - pg_dev(pg_off))) | (fb_s > 16'(target + pg_dev(pg_off)));
    next_pg = o_output_ok_pin ? ~pg_out : pg_in;
    if (!next_run || phase != PH_REGULATE || !ramp_done || (|hits))
      next_pg = 1'b0;
  end

  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      phase <= PH_OFF;
      uvlo_ok <= 1'b0;
      latched <= 1'b0;
      tick <= '0;
      status <= '0;
      o_run <= 1'b0;
      o_ref_mv <= '0;
      o_output_ok_pin <= 1'b0;
      o_alert <= 1'b0;
      o_continuous_conduction <= 1'b0;
      o_dead_time_long <= 1'b0;
    end
    else
    begin
      phase <= next_phase;
      uvlo_ok <= next_uvlo_ok;
      latched <= next_latched;
      tick <= next_tick;
      status <= next_status;
      o_run <= next_run;
      o_ref_mv <= next_ref;
      o_output_ok_pin <= next_pg;
      o_alert <= next_alert;
      o_continuous_conduction <= 1'b1;
      o_dead_time_long <= next_scratch[`SCR_DEAD_BIT];
    end
  end

  // Current readback: block average of sixteen samples, negative results read as zero.
  logic [3:0] cnt, next_cnt;
  logic signed [19:0] acc, next_acc, sum;
  logic [15:0] next_iout;
  always_comb
  begin
    next_cnt = cnt;
    next_acc = acc;
    next_iout = iout;
    sum = 20'(acc + 20'(signed'(current_sense_pins_s)));
    if (strobe_rise)
    begin
      next_cnt = 4'(cnt + 4'h1);
      next_acc = sum;
      if (cnt == `AVG_LAST)
      begin
        next_acc = '0;
        next_iout = sum[19] ? 16'h0000 : sum[`AVG_SHIFT+15:`AVG_SHIFT];
      end
    end
  end

  always_ff @(posedge i_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt <= '0;
      acc <= '0;
      iout <= '0;
    end
    else
    begin
      cnt <= next_cnt;
      acc <= next_acc;
      iout <= next_iout;
    end
  end

  a_pin_mode_only: assert property (@(posedge i_clk) disable iff (!rst_n)
    (onoff[`ONOFF_CMD_BIT:`ONOFF_PIN_BIT] == 2'b01 && !pin_act) |=> !o_run)
    else $error("pin mode ran with pin inactive");
  a_cmd_mode_only: assert property (@(posedge i_clk) disable iff (!rst_n)
    (onoff[`ONOFF_CMD_BIT:`ONOFF_PIN_BIT] == 2'b10 && !cmd_on) |=> !o_run)
    else $error("command mode ran with command off");
  a_both_needed: assert property (@(posedge i_clk) disable iff (!rst_n)
    (onoff[`ONOFF_CMD_BIT:`ONOFF_PIN_BIT] == 2'b11 && !(pin_act && cmd_on)) |=> !o_run)
    else $error("combined mode ran without both sources");
  a_pg_when_off: assert property (@(posedge i_clk) disable iff (!rst_n)
    (!o_run || latched) |-> !o_output_ok_pin)
    else $error("power good high while off");
  a_latch_holds: assert property (@(posedge i_clk) disable iff (!rst_n)
    (latched && en_req) |=> latched && !o_run)
    else $error("latch-off released without enable toggle");
  a_clear_faults: assert property (@(posedge i_clk) disable iff (!rst_n)
    (clr && hits == 4'h0) |=> (status == 4'h0) && !o_alert)
    else $error("clear faults did not clear status");
  a_ramp_slope: assert property (@(posedge i_clk) disable iff (!rst_n)
    (o_run && $past(o_run) && o_ref_mv != $past(o_ref_mv)) |=> (!o_run || o_ref_mv == $past(o_ref_mv)))
    else $error("reference stepped on consecutive cycles");
  a_lock_sticks: assert property (@(posedge i_clk) disable iff (!rst_n)
    locked |=> locked && $stable(scratch) && $stable(ov_lim))
    else $error("locked parameters changed");
  a_iout_nonneg: assert property (@(posedge i_clk) disable iff (!rst_n)
    (strobe_rise && cnt == `AVG_LAST && sum[19]) |=> iout == 16'h0000)
    else $error("negative average not reported as zero");
endmodule

// *** power_stage_model.sv ***
// Behavioural power stage that answers the controller with feedback and strobed current samples.
`timescale 1ns/1ps
module power_stage_model (
  // Clock
  input wire logic i_clk,
  // Controller outputs and bench settings
  input wire logic i_run,
  input wire logic [15:0] i_ref_mv,
  input wire logic signed [15:0] i_offset_mv,
  input wire logic signed [15:0] i_isample,
  // Sense values returned to the controller
  output logic [15:0] o_feedback_mv,
  output logic [15:0] o_isense_mv,
  output logic o_strobe
);
  logic [2:0] phase = 3'b000;
  always_ff @(negedge i_clk)
  begin
    phase <= phase + 3'b001;
  end
  // A stopped stage delivers no output, so feedback collapses instead of holding the reference.
  assign o_feedback_mv = i_run ? i_ref_mv + i_offset_mv : 16'h0000;
  // Ripple swings around the mean, so only a true average reports the mean value.
  assign o_isense_mv = phase[2] ? i_isample + 16'sh0008 : i_isample - 16'sh0008;
  assign o_strobe = phase[1];
endmodule

// *** tb_top.sv ***
// Self-checking testbench for the converter enable, fault and power-good block.
`timescale 1ns/1ps
`include "converter_defs.svh"
module tb_top;
  import converter_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  cmd_t cmd = '0;
  rsp_t rsp;
  logic pin = 1'b0;
  logic [15:0] vin = 16'h000c;
  logic oc = 1'b0;
  logic ot = 1'b0;
  logic signed [15:0] offs = 16'sh0000;
  logic signed [15:0] isample = 16'sh0000;
  logic [15:0] feedback;
  logic [15:0] isense;
  logic strobe;
  logic run;
  logic [15:0] ref_mv;
  logic cont;
  logic dead;
  logic ok;
  logic alert;
  logic [15:0] rd;
  int n_fail = 0;
  int checks = 0;
  converter_enable_fault_control #(.SS_CYC0(600), .SS_CYC1(1200), .SS_CYC2(1800), .SS_CYC3(2400)) uut (
    .i_clk(clk), .i_resetn(resetn), .i_cmd(cmd), .o_rsp(rsp), .i_enable_input_pin(pin),
    .i_vin_code(vin), .i_feedback_pin_mv(feedback), .i_oc_trip(oc), .i_ot_trip(ot),
    .i_current_sense_pins_mv(isense), .i_current_sense_pins_strobe(strobe), .o_run(run), .o_ref_mv(ref_mv),
    .o_continuous_conduction(cont), .o_dead_time_long(dead), .o_output_ok_pin(ok), .o_alert(alert));
  power_stage_model stage (.i_clk(clk), .i_run(run), .i_ref_mv(ref_mv), .i_offset_mv(offs),
    .i_isample(isample), .o_feedback_mv(feedback), .o_isense_mv(isense), .o_strobe(strobe));
  initial
  begin
    forever #25 clk = ~clk;
  end
  task automatic summarize;
    if (n_fail == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp1(input logic got, input logic exp);
    cmp16({15'h0000, got}, {15'h0000, exp});
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic wr(input logic [7:0] code, input logic [15:0] data);
    @(negedge clk);
    cmd <= '{1'b1, 1'b1, code, data};
    @(negedge clk);
    cmd.valid <= 1'b0;
  endtask
  task automatic rdreg(input logic [7:0] code, output logic [15:0] data);
    int n;
    n = 0;
    @(negedge clk);
    cmd <= '{1'b1, 1'b0, code, 16'h0000};
    @(negedge clk);
    cmd.valid <= 1'b0;
    while (rsp.valid !== 1'b1 && n < 4)
    begin
      @(negedge clk);
      n++;
    end
    data = rsp.data;
  endtask
  task automatic chk(input logic [7:0] code, input logic [15:0] exp);
    rdreg(code, rd);
    cmp16(rd, exp);
  endtask
  task automatic wait_ok(input logic exp);
    int n;
    n = 0;
    while (ok !== exp && n < 4000)
    begin
      @(negedge clk);
      n++;
    end
    cmp1(ok, exp);
  endtask
  task automatic t_reset;
    cmp1(run, 1'b0);
    cmp1(cont, 1'b1);
    chk(`CMD_ON_OFF_CONFIG, 16'h0017);
    chk(`CMD_OPERATION, 16'h0000);
    rdreg(8'h10, rd);
    cmp1(rsp.err, 1'b1);
  endtask
  task automatic t_pin;
    pin <= 1'b1;
    tick(6);
    cmp1(run, 1'b1);
    tick(20);
    cmp1(ok, 1'b0);
    wait_ok(1'b1);
    pin <= 1'b0;
    tick(6);
    cmp1(run, 1'b0);
    cmp1(ok, 1'b0);
  endtask
  task automatic t_polarity;
    wr(`CMD_ON_OFF_CONFIG, 16'h0015);
    pin <= 1'b1;
    tick(6);
    cmp1(run, 1'b0);
    pin <= 1'b0;
    tick(6);
    cmp1(run, 1'b1);
    wr(`CMD_ON_OFF_CONFIG, 16'h0017);
    tick(6);
    cmp1(run, 1'b0);
  endtask
  task automatic t_command;
    wr(`CMD_ON_OFF_CONFIG, 16'h001b);
    pin <= 1'b1;
    tick(6);
    cmp1(run, 1'b0);
    wr(`CMD_OPERATION, 16'h0080);
    pin <= 1'b0;
    tick(6);
    cmp1(run, 1'b1);
    wr(`CMD_ON_OFF_CONFIG, 16'h001f);
    tick(6);
    cmp1(run, 1'b0);
    pin <= 1'b1;
    tick(6);
    cmp1(run, 1'b1);
    wr(`CMD_OPERATION, 16'h0000);
    tick(6);
    cmp1(run, 1'b0);
  endtask
  task automatic t_neither;
    wr(`CMD_ON_OFF_CONFIG, 16'h0013);
    pin <= 1'b0;
    tick(6);
    cmp1(run, 1'b1);
    vin <= 16'h0009;
    tick(6);
    cmp1(run, 1'b0);
    wr(`CMD_INPUT_TURN_ON_LEVEL, 16'h000e);
    chk(`CMD_INPUT_TURN_ON_LEVEL, 16'h000e);
    vin <= 16'h000c;
    tick(6);
    cmp1(run, 1'b0);
    vin <= 16'h000f;
    tick(6);
    cmp1(run, 1'b1);
    wr(`CMD_ON_OFF_CONFIG, 16'h0017);
    pin <= 1'b1;
    wait_ok(1'b1);
  endtask
  task automatic t_window;
    int o[6] = '{20, 50, 35, -20, -50, 0};
    logic e[6] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
    wr(`CMD_PG_ON, 16'h0000);
    wr(`CMD_PG_OFF, 16'h0001);
    foreach (o[k])
    begin
      offs <= o[k][15:0];
      tick(6);
      cmp1(ok, e[k]);
    end
    // The tightest overvoltage code trips above 48 mV over target, so 55 mV trips it while the default code (60 mV) tolerates it.
    wr(`CMD_OV_LIMIT, 16'h0000);
    offs <= 16'sh0037;
    tick(6);
    chk(`CMD_FAULT_STATUS, 16'h0001);
    offs <= 16'sh0000;
    wr(`CMD_OV_LIMIT, `RST_OV_LIMIT);
    wr(`CMD_CLEAR_FAULTS, 16'h0000);
    tick(6);
    chk(`CMD_FAULT_STATUS, 16'h0000);
  endtask
  task automatic t_margin;
    wr(`CMD_OPERATION, 16'h0020);
    tick(4);
    cmp1(ref_mv < `REF_NOM_MV + `RST_MARGIN, 1'b1);
    tick(100);
    cmp16(ref_mv, `REF_NOM_MV + `RST_MARGIN);
    wr(`CMD_OPERATION, 16'h0010);
    tick(200);
    cmp16(ref_mv, `REF_NOM_MV - `RST_MARGIN);
    wr(`CMD_VOUT_TRIM, 16'h0005);
    wr(`CMD_OPERATION, 16'h0000);
    tick(150);
    cmp16(ref_mv, `REF_NOM_MV + 16'h0005);
    wr(`CMD_VOUT_TRIM, 16'h0000);
    tick(30);
  endtask
  task automatic t_iout;
    isample <= 16'sh0040;
    tick(200);
    chk(`CMD_READ_IOUT, 16'h0040);
    isample <= -16'sh0020;
    tick(200);
    chk(`CMD_READ_IOUT, 16'h0000);
  endtask
  task automatic inject(input int k, input logic on);
    case (k)
      0: offs <= on ? 16'sh0064 : 16'sh0000;
      1: offs <= on ? -16'sh0064 : 16'sh0000;
      2: oc <= on;
      default: ot <= on;
    endcase
  endtask
  task automatic t_faults;
    logic [7:0] act[4] = '{`CMD_OV_ACTION, `CMD_UV_ACTION, `CMD_OC_ACTION, `CMD_OT_ACTION};
    for (int k = 0; k < 4; k++)
    begin
      wait_ok(1'b1);
      inject(k, 1'b1);
      tick(10);
      cmp1(run, 1'b1);
      inject(k, 1'b0);
      wr(`CMD_CLEAR_FAULTS, 16'h0000);
      wr(act[k], 16'h0080);
      wait_ok(1'b1);
      inject(k, 1'b1);
      tick(10);
      cmp1(run, 1'b0);
      cmp1(ok, 1'b0);
      cmp1(alert, 1'b1);
      chk(`CMD_FAULT_STATUS, 16'h0001 << k);
      inject(k, 1'b0);
      tick(50);
      cmp1(run, 1'b0);
      wr(`CMD_CLEAR_FAULTS, 16'h0000);
      tick(2);
      cmp1(alert, 1'b0);
      chk(`CMD_FAULT_STATUS, 16'h0000);
      wr(act[k], {8'h00, `RST_ACTION});
      pin <= 1'b0;
      tick(6);
      pin <= 1'b1;
      tick(6);
      cmp1(run, 1'b1);
    end
  endtask
  task automatic t_softstart;
    logic [15:0] a;
    int exp;
    for (int c = 0; c < 4; c++)
    begin
      pin <= 1'b0;
      wr(`CMD_SOFT_START_DURATION, c[15:0]);
      tick(6);
      pin <= 1'b1;
      tick(20);
      a = ref_mv;
      tick(60);
      exp = 60 / (c + 2);
      cmp1((ref_mv - a) >= exp - 1 && (ref_mv - a) <= exp + 1, 1'b1);
    end
    wr(`CMD_SOFT_START_DURATION, 16'h0000);
  endtask
  task automatic t_scratch;
    wr(`CMD_SCRATCHPAD, 16'h0001);
    tick(2);
    cmp1(dead, 1'b1);
    wr(`CMD_SCRATCHPAD, 16'hfffd);
    chk(`CMD_SCRATCHPAD, 16'h3ffd);
    wr(`CMD_SCRATCHPAD, 16'h0000);
    tick(2);
    cmp1(dead, 1'b0);
    wr(`CMD_SCRATCHPAD, 16'h0002);
    wr(`CMD_SOFT_START_DURATION, 16'h0003);
    chk(`CMD_SOFT_START_DURATION, 16'h0000);
    wr(`CMD_SCRATCHPAD, 16'h0001);
    chk(`CMD_SCRATCHPAD, 16'h0002);
  endtask
  initial
  begin
    tick(8);
    resetn <= 1'b1;
    tick(6);
    t_reset;
    t_pin;
    t_polarity;
    t_command;
    t_neither;
    t_window;
    t_margin;
    t_iout;
    t_faults;
    t_softstart;
    t_scratch;
    summarize;
  end
  // Runs are near 11000 cycles; the 60000-cycle limit leaves a wide margin for the slowest ramps.
  initial
  begin
    #3_000_000;
    n_fail++;
    summarize;
  end
endmodule
